// File: hpc_cfg.svh
// Constants for the host port mode and control block.
`ifndef HPC_CFG_SVH
`define HPC_CFG_SVH
`define HPC_CLK_HZ 10000000
`define HPC_NREGS 16
`define HPC_AW 4
`define HPC_REG_RESET 8'h00
`define HPC_RATE_E1_HZ 2048000
`define HPC_RATE_T1_HZ 1544000
`define HPC_NFRAMERS 16
`define HPC_GMASK_BIT 0
`endif

// File: hpc_host_model.sv
// Parallel bus host that drives the block's strobes in either style.
`timescale 1ns/100ps
module hpc_host_model (
   input wire logic clk,
   output logic chip_select_n,
   output logic write_strobe_n,
   output logic read_strobe_n,
   output logic [3:0] address,
   output logic [7:0] host_data
);
   // The model is the only driver of these pins, so it sets them idle here.
   initial begin
      chip_select_n = 1'b1;
      write_strobe_n = 1'b1;
      read_strobe_n = 1'b1;
      address = 4'h0;
      host_data = 8'h00;
   end
   // Strobes held 6 low, cs and data held past the rise.
   task automatic access(input logic sty, input logic wr,
      input logic [3:0] a, input logic [7:0] d, input logic cs_n);
      @(posedge clk);
      chip_select_n <= cs_n;
      address <= a;
      host_data <= d;
      write_strobe_n <= !wr;
      read_strobe_n <= sty ? 1'b0 : wr;
      repeat (6) @(posedge clk);
      read_strobe_n <= 1'b1;
      if (!sty) write_strobe_n <= 1'b1;
      repeat (4) @(posedge clk);
      chip_select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      // Released data shows a changed value, never the last one.
      host_data <= ~d;
      repeat (5) @(posedge clk);
   endtask : access
endmodule : hpc_host_model

// File: hpc_host_port.sv
// Host port strobe qualification, mode selection, interrupt and clock select.
`timescale 1ns/100ps
`include "hpc_cfg.svh"
// Notes on behaviour
// [R1] Data bus captured into addressed register on write strobe rise, chip select low.
// [R2] Interrupt output driven low while any unmasked event is pending.
// [R3] Interrupt output released, not driven high, once nothing is pending.
// [R4] Mask bits at global, framer, line interface and bit error tester level.
// [R5] Serial port select 0 gives parallel bus, 1 gives serial slave.
// [R6] Bus style high: data strobe plus direction; low: separate read, write.
// [R7] The system holds bus style low whenever serial mode is selected.
// [R8] Master clock at either base rate, adapted to the other by settings.
// [R9] Port transmit clock is 2.048MHz for E1, 1.544MHz for T1 or J1.
// [R10] Device reset returns all registers and units to reset state; the test port flops and id_reg are not reset by it.
// [R11] Backplane reference chosen from reference pin, line clocks or master.
// [R12] Reference pin as output drives a 1.544MHz or 2.048MHz clock.
// [R13] Digital I/O float when enable and test reset are both low.
// [R14] Test port reset clears the test access controller asynchronously.
// [R15] Test reset raised after power-up gives identification mode; low is normal.
// [R16] Read drives bus while read strobe and chip select low, else undriven.
// [R17] Serial bit order swap: 0 least significant first, 1 most first.
// [R18] Write strobe edges with chip select high change nothing.
module hpc_host_port #(
   parameter int NREGS = `HPC_NREGS,
   parameter int AW = `HPC_AW
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic device_reset_n,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic [AW-1:0] address,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic serial_port_select,
   input wire logic bus_style_select,
   input wire logic spi_bit_order_swap,
   output logic serial_mode,
   output logic serial_msb_first,
   input wire logic [3:0] event_framer,
   input wire logic [3:0] event_line_interface,
   input wire logic [3:0] event_bit_error_tester,
   output logic interrupt_request_n_out,
   output logic interrupt_request_n_oe,
   input wire logic master_prescale_bit0,
   input wire logic master_prescale_bit1,
   input wire logic master_frequency_select,
   input wire logic port_is_e1,
   output logic [1:0] master_clock_adapt,
   output logic [23:0] port_transmit_rate_hz,
   input wire logic [1:0] backplane_ref_select,
   input wire logic reference_clock_pin_in,
   input wire logic line_recovered_clock,
   input wire logic master_clock_ref,
   input wire logic reference_pin_output_mode,
   output logic backplane_reference,
   output logic reference_clock_pin_out,
   output logic reference_clock_pin_oe,
   input wire logic digital_io_enable,
   input wire logic test_port_reset_n,
   output logic digital_io_float,
   output logic test_port_id_mode
);
   hpc_pkg::hpc_strobes_s s1_reg, s2_reg, s3_reg;
   hpc_pkg::hpc_state_e state_reg, state_next;
   logic [7:0] regs [NREGS];
   logic [AW-1:0] addr1_reg, addr2_reg;
   logic [7:0] d1_reg, d2_reg;
   logic [2:0] ctl1_reg, ctl2_reg;
   logic [3:0] en1_reg, en2_reg;
   logic [2:0] clk1_reg, clk2_reg;
   logic tr1_reg, tr2_reg, id_reg;
   logic test_ctrl_reset_reg;
   logic wr_level, rd_level, wr_rise, pending;
   hpc_pkg::hpc_bus_drive_s drive_reg;

   // Double-flop the strobe, address, data, mode, enable and clock pins before any logic looks at them.
   always_ff @(posedge clk) begin
      s1_reg <= {chip_select_n, write_strobe_n, read_strobe_n};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      addr1_reg <= address;
      addr2_reg <= addr1_reg;
      d1_reg <= data_in;
      d2_reg <= d1_reg;
      ctl1_reg <= {serial_port_select, bus_style_select, spi_bit_order_swap};
      ctl2_reg <= ctl1_reg;
      en1_reg <= {digital_io_enable, reference_pin_output_mode,
                  backplane_ref_select};
      en2_reg <= en1_reg;
      clk1_reg <= {reference_clock_pin_in, line_recovered_clock,
                   master_clock_ref};
      clk2_reg <= clk1_reg;
   end

   // [R6] strobe style decode
   // With bus style high, the write line carries direction (low = write).
   assign wr_level = ctl2_reg[1] ? (!s2_reg.read_strobe_n &&
                                    !s2_reg.write_strobe_n)
                                 : !s2_reg.write_strobe_n;
   assign rd_level = ctl2_reg[1] ? (!s2_reg.read_strobe_n &&
                                    s2_reg.write_strobe_n)
                                 : !s2_reg.read_strobe_n;
   // [R1] rising edge capture
   // [R18] chip select qualifies
   // The end of the write phase is taken as the capture point, so data must
   // be stable across the strobe rise plus two synchroniser cycles.
   assign wr_rise = (state_reg == hpc_pkg::HPC_ACCESS) && !wr_level &&
                    !s3_reg.chip_select_n && !s2_reg.chip_select_n;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         hpc_pkg::HPC_IDLE: begin
            if (wr_level && !s2_reg.chip_select_n && !ctl2_reg[2]) begin
               state_next = hpc_pkg::HPC_ACCESS;
            end
         end
         hpc_pkg::HPC_ACCESS: begin
            if (s2_reg.chip_select_n) begin
               state_next = hpc_pkg::HPC_IDLE;
            end else if (!wr_level) begin
               state_next = hpc_pkg::HPC_DONE;
            end
         end
         hpc_pkg::HPC_DONE: begin
            state_next = hpc_pkg::HPC_IDLE;
         end
         default: begin
            state_next = hpc_pkg::HPC_IDLE;
         end
      endcase
   end

   // [R10] device reset
   always_ff @(posedge clk) begin
      if (!reset_n || !device_reset_n) begin
         state_reg <= hpc_pkg::HPC_IDLE;
         for (int i = 0; i < NREGS; i++) begin
            regs[i] <= `HPC_REG_RESET;
         end
      end else begin
         state_reg <= state_next;
         if (wr_rise) begin
            regs[addr2_reg] <= d2_reg;
         end
      end
   end

   // [R4] four mask levels
   // Register 0 bit 0 is the global mask; registers 1..3 mask each group.
   assign pending = !regs[0][`HPC_GMASK_BIT] &&
                    (|(event_framer & ~regs[1][3:0]) ||
                     |(event_line_interface & ~regs[2][3:0]) ||
                     |(event_bit_error_tester & ~regs[3][3:0]));

   always_ff @(posedge clk) begin
      if (!reset_n || !device_reset_n) begin
         interrupt_request_n_out <= 1'b0;
         interrupt_request_n_oe <= 1'b0;
         drive_reg <= '0;
         serial_mode <= 1'b0;
         serial_msb_first <= 1'b0;
         master_clock_adapt <= 2'h0;
         port_transmit_rate_hz <= 24'h000000;
         backplane_reference <= 1'b0;
         reference_clock_pin_out <= 1'b0;
         reference_clock_pin_oe <= 1'b0;
         digital_io_float <= 1'b0;
      end else begin
         // [R2] assert on unmasked
         // [R3] release when clear
         interrupt_request_n_out <= 1'b0;
         interrupt_request_n_oe <= pending && !digital_io_float;
         // [R16] read drive
         drive_reg.out <= regs[addr2_reg];
         drive_reg.oe <= rd_level && !s2_reg.chip_select_n &&
                         !ctl2_reg[2] && !digital_io_float;
         // [R5] port mode select
         serial_mode <= ctl2_reg[2];
         // [R17] bit order swap
         serial_msb_first <= ctl2_reg[2] && ctl2_reg[0];
         // [R8] master clock adapt
         master_clock_adapt <= {master_prescale_bit1 ^ master_frequency_select,
                                master_prescale_bit0};
         // [R9] transmit rate
         port_transmit_rate_hz <= port_is_e1 ? 24'(`HPC_RATE_E1_HZ)
                                             : 24'(`HPC_RATE_T1_HZ);
         // [R11] backplane source
         backplane_reference <= (en2_reg[1:0] == 2'h0) ? clk2_reg[2] :
                                (en2_reg[1:0] == 2'h1) ? clk2_reg[1] :
                                clk2_reg[0];
         // [R12] reference output
         reference_clock_pin_out <= clk2_reg[0];
         reference_clock_pin_oe <= en2_reg[2] && !digital_io_float;
         // [R13] io float
         digital_io_float <= !en2_reg[3] && !tr2_reg;
      end
   end
   assign data_out = drive_reg.out;
   assign data_oe = drive_reg.oe;

   // [R14] async test reset
   always_ff @(posedge clk or negedge test_port_reset_n) begin
      if (!test_port_reset_n) begin
         test_ctrl_reset_reg <= 1'b1;
         tr1_reg <= 1'b0;
         tr2_reg <= 1'b0;
      end else begin
         test_ctrl_reset_reg <= 1'b0;
         tr1_reg <= 1'b1;
         tr2_reg <= tr1_reg;
      end
   end
   // [R15] identification mode
   always_ff @(posedge clk) begin
      if (!reset_n || test_ctrl_reset_reg) begin
         id_reg <= 1'b0;
      end else begin
         id_reg <= tr2_reg;
      end
   end
   assign test_port_id_mode = id_reg;
endmodule : hpc_host_port

// File: hpc_host_port_asserts.sv
// Concurrent checks on the host port mode and control block.
`timescale 1ns/100ps
module hpc_host_port_checker (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic device_reset_n,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic bus_style_select,
   input wire logic serial_port_select,
   input wire logic data_oe,
   input wire logic serial_mode,
   input wire logic interrupt_request_n_out,
   input wire logic interrupt_request_n_oe,
   input wire logic master_prescale_bit0,
   input wire logic master_prescale_bit1,
   input wire logic master_frequency_select,
   input wire logic [1:0] master_clock_adapt,
   input wire logic port_is_e1,
   input wire logic [23:0] port_transmit_rate_hz,
   input wire logic reference_pin_output_mode,
   input wire logic reference_clock_pin_oe,
   input wire logic digital_io_enable,
   input wire logic test_port_reset_n,
   input wire logic digital_io_float
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n || !device_reset_n);
   property p_irq_low; interrupt_request_n_out == 1'b0; endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("interrupt pin driven high");
   property p_mode; $stable(serial_port_select)[*5] |->
      serial_mode == serial_port_select; endproperty
   a_mode: assert property (p_mode)
      else $error("host port mode wrong");
   property p_adapt; $stable({master_prescale_bit0, master_prescale_bit1,
      master_frequency_select})[*3] |-> master_clock_adapt ==
      {master_prescale_bit1 ^ master_frequency_select,
      master_prescale_bit0}; endproperty
   a_adapt: assert property (p_adapt)
      else $error("clock adapt wrong");
   property p_rate; $stable(port_is_e1)[*3] |-> port_transmit_rate_hz ==
      (port_is_e1 ? 24'h1F4000 : 24'h178F40); endproperty
   a_rate: assert property (p_rate)
      else $error("transmit rate wrong");
   // The pin also floats with the rest of the digital I/O.
   property p_ref_dir; $stable({reference_pin_output_mode, digital_io_enable,
      test_port_reset_n})[*5] |-> reference_clock_pin_oe ==
      (reference_pin_output_mode && !digital_io_float); endproperty
   a_ref_dir: assert property (p_ref_dir)
      else $error("reference pin direction wrong");
   property p_float; $stable({digital_io_enable, test_port_reset_n})[*4]
      |-> digital_io_float == (!digital_io_enable && !test_port_reset_n);
   endproperty
   a_float: assert property (p_float)
      else $error("io float wrong");
   property p_bus_idle; chip_select_n[*5] |-> !data_oe; endproperty
   a_bus_idle: assert property (p_bus_idle)
      else $error("bus driven while deselected");
   property p_bus_read; (!chip_select_n && !read_strobe_n && write_strobe_n
      && !bus_style_select && !serial_port_select && !digital_io_float)[*6]
      |-> data_oe;
   endproperty
   a_bus_read: assert property (p_bus_read)
      else $error("bus not driven during read");
   c_read: cover property ($rose(data_oe));
   c_serial: cover property ($rose(serial_mode));
   c_irq: cover property ($rose(interrupt_request_n_oe));
endmodule : hpc_host_port_checker
bind hpc_host_port hpc_host_port_checker u_chk (.*);

// File: hpc_pkg.sv
// Types for the host port mode and control block.
package hpc_pkg;
   typedef enum logic [2:0] {
      HPC_IDLE = 3'b001,
      HPC_ACCESS = 3'b010,
      HPC_DONE = 3'b100
   } hpc_state_e;
   typedef struct packed {
      logic chip_select_n;
      logic write_strobe_n;
      logic read_strobe_n;
   } hpc_strobes_s;
   typedef struct packed {
      logic [7:0] out;
      logic oe;
   } hpc_bus_drive_s;
endpackage : hpc_pkg

// File: tb_top.sv
// Self-checking testbench for the host port mode and control block.
`timescale 1ns/100ps
module tb_top;
   logic clk = 0, reset_n = 0, device_reset_n = 0, chip_select_n;
   logic write_strobe_n, read_strobe_n, data_oe, serial_port_select = 0;
   logic bus_style_select = 0, spi_bit_order_swap = 0, serial_mode;
   logic serial_msb_first, interrupt_request_n_out, interrupt_request_n_oe;
   logic master_prescale_bit0 = 0, master_prescale_bit1 = 0;
   logic master_frequency_select = 0, port_is_e1 = 0;
   logic line_recovered_clock = 0, master_clock_ref = 0, ref_drv = 0;
   logic reference_pin_output_mode = 0, backplane_reference, seen = 0;
   logic reference_clock_pin_out, reference_clock_pin_oe, test_port_id_mode;
   logic digital_io_enable = 1, test_port_reset_n = 0, digital_io_float;
   logic reference_clock_pin_in;
   logic [3:0] address, event_framer = 0, event_line_interface = 0;
   logic [3:0] event_bit_error_tester = 0;
   logic [7:0] data_in, data_out, host_data, d;
   logic [1:0] master_clock_adapt, backplane_ref_select = 0;
   logic [23:0] port_transmit_rate_hz;
   logic [7:0] q[$];
   int miscompares = 0, comparisons = 0;
   assign data_in = data_oe ? data_out : host_data;
   assign reference_clock_pin_in = reference_clock_pin_oe ?
      reference_clock_pin_out : ref_drv;
   always #50 clk = ~clk;
   hpc_host_port uut (.*);
   hpc_host_model host (.*);
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic end_sim();
      if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   task automatic rd(input logic sty, input logic [3:0] a, input logic [7:0] e);
      q.push_back(e);
      host.access(sty, 1'b0, a, 8'h00, 1'b0);
      if (q.size() != 0) begin
         miscompares++;
         end_sim();
      end
   endtask : rd
   always @(posedge clk) begin
      if (data_oe === 1'b1 && !seen && q.size() != 0)
         check(24'(data_out), 24'(q.pop_front()));
      seen <= data_oe;
   end
   initial begin
      void'($urandom(32'h98C5));
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      device_reset_n <= 1'b1;
      for (int s = 0; s < 2; s++) begin
         d = 8'($urandom);
         bus_style_select <= s[0];
         host.access(s[0], 1'b1, 4'h5 + 4'(s), d, 1'b0);
         rd(s[0], 4'h5 + 4'(s), d);
         host.access(s[0], 1'b1, 4'h5 + 4'(s), ~d, 1'b1);
         rd(s[0], 4'h5 + 4'(s), d);
      end
      @(posedge clk) device_reset_n <= 1'b0;
      repeat (3) @(posedge clk) device_reset_n <= 1'b1;
      rd(1'b1, 4'h6, 8'h00);
      bus_style_select <= 1'b0;
      event_framer <= 4'h1;
      repeat (4) @(posedge clk);
      check(24'(interrupt_request_n_oe), 24'h000001);
      host.access(1'b0, 1'b1, 4'h0, 8'h01, 1'b0);
      check(24'(interrupt_request_n_oe), 24'h000000);
      event_framer <= 4'h0;
      host.access(1'b0, 1'b1, 4'h0, 8'h00, 1'b0);
      check(24'(interrupt_request_n_oe), 24'h000000);
      // Random mode and clock settings; levels settle within eight cycles.
      // bus style held low
      repeat (30) begin
         {serial_port_select, spi_bit_order_swap, master_prescale_bit0,
            master_prescale_bit1, master_frequency_select, port_is_e1,
            reference_pin_output_mode, digital_io_enable, test_port_reset_n,
            ref_drv, line_recovered_clock, master_clock_ref,
            backplane_ref_select} <= 14'($urandom);
         repeat (8) @(posedge clk);
         check(24'(serial_msb_first),
            24'(serial_port_select && spi_bit_order_swap));
         check(24'(reference_clock_pin_out), 24'(master_clock_ref));
         check(24'(test_port_id_mode), 24'(test_port_reset_n));
         check(24'(backplane_reference), 24'((backplane_ref_select == 2'h0) ?
            reference_clock_pin_in : (backplane_ref_select == 2'h1) ?
            line_recovered_clock : master_clock_ref));
      end
      end_sim();
   end
endmodule : tb_top
